// >>> core/asc_pkg.sv
// asc_pkg: constants and types for the sample/convert sequencer
// assumes a 16-bit register port and the 20 MHz system clock
package asc_pkg;
  localparam int unsigned CLK_HZ        = 20000000;
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_IRQ_STAT = 4'h1;
  localparam logic [3:0]  ADDR_IRQ_MASK = 4'h2;
  localparam logic [3:0]  ADDR_CHAN     = 4'h3;
  localparam int unsigned SRC_MSB       = 7;
  localparam int unsigned SRC_LSB       = 5;
  localparam int unsigned GRP_BIT       = 4;
  localparam int unsigned SIM_BIT       = 3;
  localparam int unsigned SAMPLE_AUTO_START_BIT      = 2;
  localparam int unsigned SAMPLE_ENABLE_BIT      = 1;
  localparam int unsigned DONE_BIT      = 0;
  localparam int unsigned CHANNEL_COUNT_SELECT_LSB      = 0;
  localparam int unsigned B12_BIT       = 2;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [2:0]  CHAN_RESET    = 3'h0;
  localparam logic [1:0]  IRQ_RESET     = 2'h0;
  localparam int unsigned IRQ_DONE      = 0;
  localparam int unsigned IRQ_START     = 1;
  localparam int unsigned CONV_NS       = 700;
  localparam int unsigned CONV_CYCLES   =
    (CONV_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned AUTO_NS       = 150;
  localparam int unsigned AUTO_CYCLES   =
    (AUTO_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [2:0]  SRC_MANUAL    = 3'h0;
  localparam logic [2:0]  SRC_AUTO      = 3'h7;
  typedef enum logic [1:0] {
    ASC_IDLE   = 2'b00,
    ASC_SAMPLE = 2'b01,
    ASC_CONV   = 2'b10
  } asc_state_t;
endpackage

// >>> core/asc_sync.sv
// asc_sync: two-stage synchroniser for a bundle of levels
// assumes inputs come from outside the clock domain
`timescale 1ns/100ps
module asc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         en_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta  <= '0;
      q_out <= '0;
    end else if (en_in) begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule // asc_sync

// >>> core/asc_trig_mux.sv
// asc_trig_mux: picks the start event for the current source code
// assumes all trigger inputs are single-cycle pulses in the clock domain
`timescale 1ns/100ps
module asc_trig_mux (
  input  wire logic       group_in,
  input  wire logic [2:0] source_in,
  input  wire logic [2:0] pwm_pri_in,
  input  wire logic [3:0] tgen_in,
  input  wire logic       auto_in,
  input  wire logic       ctu_in,
  input  wire logic       pwm_sec_sev_in,
  input  wire logic       tmr5_in,
  input  wire logic       pwm_pri_sev_in,
  input  wire logic       tmr3_in,
  input  wire logic       pin0_edge_in,
  output logic            fire_out
);
  always_comb begin
    fire_out = 1'b0;
    if (group_in) begin
      unique case (source_in)
        3'h0: fire_out = pwm_pri_in[0];   // [R01]
        3'h1: fire_out = pwm_pri_in[1];   // [R01]
        3'h2: fire_out = pwm_pri_in[2];   // [R01]
        3'h3: fire_out = tgen_in[0];      // [R02]
        3'h4: fire_out = tgen_in[1];      // [R02]
        3'h5: fire_out = tgen_in[2];      // [R02]
        3'h6: fire_out = tgen_in[3];      // [R02]
        3'h7: fire_out = 1'b0;            // reserved code [R02]
      endcase
    end else begin
      unique case (source_in)
        3'h0: fire_out = 1'b0;            // software ends it [R06]
        3'h1: fire_out = pin0_edge_in;    // [R05]
        3'h2: fire_out = tmr3_in;         // [R04]
        3'h3: fire_out = pwm_pri_sev_in;  // [R04]
        3'h4: fire_out = tmr5_in;         // [R04]
        3'h5: fire_out = pwm_sec_sev_in;  // [R04]
        3'h6: fire_out = ctu_in;          // [R04]
        3'h7: fire_out = auto_in;         // [R03]
      endcase
    end
  end
endmodule // asc_trig_mux

// >>> core/asc_core.sv
// asc_core: sample/convert sequencing with control register and irq
// assumes trigger sources are one-cycle pulses on clk_in, pin async
//
// Notes on behaviour
// R01: group one, codes 0-2 pick PWM 1-3
// R02: group one, codes 3-6 trigger generator, 7 reserved
// R03: group zero code 7 internal counter
// R04: group zero codes 2-6 timers, PWM, charge unit
// R05: group zero code 1 external pin edge
// R06: manual mode: clearing sample bit starts conversion
// R07: source bits 7:5, group bit 4
// R08: simultaneous sampling of two or four channels
// R09: twelve-bit mode hides simultaneous bit, reads zero
// R10: auto-start resamples after conversion, sets sample bit
// R11: without auto-start, software sets sample bit
// R12: sample bit one while sampling
// R13: hardware clears sample bit at trigger
// R14: done set when conversion completes
// R15: software clears done only; conversion unaffected
// R16: done cleared when new conversion begins
// R17: software should not clear done under auto-start
// R18: conversion length is a parameter
`timescale 1ns/100ps
module asc_core
  import asc_pkg::*;
#(
  parameter int unsigned CONV_LEN = asc_pkg::CONV_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  input  wire logic [2:0]  pwm_pri_in,
  input  wire logic [3:0]  tgen_in,
  input  wire logic        ctu_in,
  input  wire logic        pwm_sec_sev_in,
  input  wire logic        tmr5_in,
  input  wire logic        pwm_pri_sev_in,
  input  wire logic        tmr3_in,
  input  wire logic        ext_pin0_in,
  output logic             sampling_out,
  output logic      [3:0]  sample_chan_out,
  output logic             conv_start_out,
  output logic             conv_done_out,
  output logic             irq_out
);
  import asc_pkg::*;

  typedef struct packed {
    logic [2:0]  source;
    logic        group;
    logic        simultaneous_sample;
    logic        sample_auto_start;
    logic        sample_enable;
    logic        done;
    logic [1:0]  channel_count_select;
    logic        b12;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    asc_state_t  state;
    logic [15:0] conv_cnt;
    logic [15:0] auto_cnt;
    logic        pin_prev;
    logic        start_p;
    logic        done_p;
    logic [15:0] rdata;
  } asc_regs_t;

  asc_regs_t cur;
  asc_regs_t nxt;
  logic      rst_n;
  logic      pin_s;
  logic      fire;
  logic      auto_hit;

  // reset release through two flops; the rest uses rst_n
  logic [1:0] rst_pipe;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  asc_sync #(
    .W (1)
  ) u_pin_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .en_in    (ce_in),
    .d_in     (ext_pin0_in),
    .q_out    (pin_s)
  );

  // internal counter fires once sampling has lasted its time
  assign auto_hit = cur.state == ASC_SAMPLE &&
                    cur.auto_cnt == 16'(AUTO_CYCLES - 1);

  asc_trig_mux u_mux (
    .group_in       (cur.group),
    .source_in      (cur.source),
    .pwm_pri_in     (pwm_pri_in),
    .tgen_in        (tgen_in),
    .auto_in        (auto_hit),
    .ctu_in         (ctu_in),
    .pwm_sec_sev_in (pwm_sec_sev_in),
    .tmr5_in        (tmr5_in),
    .pwm_pri_sev_in (pwm_pri_sev_in),
    .tmr3_in        (tmr3_in),
    .pin0_edge_in   (pin_s & ~cur.pin_prev),
    .fire_out       (fire)
  );

  function automatic logic [15:0] ctrl_word(input asc_regs_t r);
    logic [15:0] w;
    w = 16'h0000;
    w[SRC_MSB:SRC_LSB] = r.source;                  // [R07]
    w[GRP_BIT]  = r.group;                          // [R07]
    w[SIM_BIT]  = r.simultaneous_sample & ~r.b12;                // [R09]
    w[SAMPLE_AUTO_START_BIT] = r.sample_auto_start;
    w[SAMPLE_ENABLE_BIT] = r.sample_enable;                           // [R12]
    w[DONE_BIT] = r.done;
    return w;
  endfunction

  always_comb begin
    logic wr_ctrl;
    logic start;
    logic sw_set;
    logic sw_clr;
    wr_ctrl = 1'b0;
    start   = 1'b0;
    sw_set  = 1'b0;
    sw_clr  = 1'b0;
    nxt = cur;
    nxt.start_p  = 1'b0;
    nxt.done_p   = 1'b0;
    nxt.pin_prev = pin_s;
    nxt.rdata    = 16'h0000;
    wr_ctrl = wr_in && addr_in == ADDR_CTRL;
    if (rd_in) begin
      unique case (addr_in)
        ADDR_CTRL:     nxt.rdata = ctrl_word(cur);
        ADDR_IRQ_STAT: nxt.rdata = {14'h0000, cur.irq_stat};
        ADDR_IRQ_MASK: nxt.rdata = {14'h0000, cur.irq_mask};
        ADDR_CHAN:     nxt.rdata = {13'h0000, cur.b12, cur.channel_count_select};
        default:       nxt.rdata = 16'h0000;
      endcase
    end
    if (wr_ctrl) begin
      nxt.source = wdata_in[SRC_MSB:SRC_LSB];       // [R07]
      nxt.group  = wdata_in[GRP_BIT];               // [R07]
      nxt.simultaneous_sample = wdata_in[SIM_BIT] & ~cur.b12;    // [R09]
      nxt.sample_auto_start   = wdata_in[SAMPLE_AUTO_START_BIT];
      sw_set = wdata_in[SAMPLE_ENABLE_BIT] & ~cur.sample_enable;
      sw_clr = ~wdata_in[SAMPLE_ENABLE_BIT] & cur.sample_enable;
      if (!wdata_in[DONE_BIT]) begin
        nxt.done = 1'b0;                            // zero clears only [R15]
      end
    end
    if (wr_in && addr_in == ADDR_IRQ_MASK) begin
      nxt.irq_mask = wdata_in[1:0];
    end
    if (wr_in && addr_in == ADDR_CHAN) begin
      nxt.channel_count_select = wdata_in[CHANNEL_COUNT_SELECT_LSB+1:CHANNEL_COUNT_SELECT_LSB];
      nxt.b12  = wdata_in[B12_BIT];
      if (wdata_in[B12_BIT]) begin
        nxt.simultaneous_sample = 1'b0;                          // [R09]
      end
    end
    if (wr_in && addr_in == ADDR_IRQ_STAT) begin
      nxt.irq_stat = cur.irq_stat & ~wdata_in[1:0];
    end
    unique case (cur.state)
      ASC_IDLE: begin
        if (sw_set) begin
          nxt.sample_enable = 1'b1;                          // [R11]
          nxt.state = ASC_SAMPLE;
          nxt.auto_cnt = 16'h0000;
        end
      end
      ASC_SAMPLE: begin
        nxt.auto_cnt = cur.auto_cnt + 16'h0001;
        if (cur.source == SRC_MANUAL && !cur.group) begin
          start = sw_clr;                           // [R06]
        end else begin
          start = fire;                             // [R13]
        end
      end
      ASC_CONV: begin
        nxt.conv_cnt = cur.conv_cnt + 16'h0001;
        // a sample-bit write during conversion is dropped, not kept for the next round
        if (cur.conv_cnt == 16'(CONV_LEN - 1)) begin
          nxt.done   = 1'b1;                        // [R14] [R18]
          nxt.done_p = 1'b1;
          if (cur.sample_auto_start) begin
            nxt.sample_enable = 1'b1;                        // [R10]
            nxt.state = ASC_SAMPLE;
            nxt.auto_cnt = 16'h0000;
          end else begin
            nxt.state = ASC_IDLE;                   // [R11]
          end
        end
      end
      default: nxt.state = ASC_IDLE;
    endcase
    if (start) begin
      nxt.sample_enable = 1'b0;                              // [R13] [R12]
      nxt.state = ASC_CONV;
      nxt.conv_cnt = 16'h0000;
      nxt.done = 1'b0;                              // [R16]
      nxt.start_p = 1'b1;
    end
    // hardware events win over a software clear of the same bit
    if (nxt.done_p) begin
      nxt.irq_stat[IRQ_DONE] = 1'b1;
    end
    if (nxt.start_p) begin
      nxt.irq_stat[IRQ_START] = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
      cur.source <= CTRL_RESET[SRC_MSB:SRC_LSB];
      cur.channel_count_select <= CHAN_RESET[1:0];
      cur.irq_stat <= IRQ_RESET;
      cur.irq_mask <= IRQ_RESET;
      cur.state <= ASC_IDLE;
    end else if (ce_in) begin
      cur <= nxt;
    end
  end

  // channel set sampled together, else channel 0 only
  function automatic logic [3:0] chan_set(input asc_regs_t r);
    logic [3:0] m;
    m = 4'h1;
    if (r.simultaneous_sample && !r.b12) begin
      if (r.channel_count_select[1]) begin
        m = 4'hF;                                   // [R08]
      end else if (r.channel_count_select == 2'h1) begin
        m = 4'h3;                                   // [R08]
      end
    end
    return m;
  endfunction

  assign rdata_out       = cur.rdata;
  assign sampling_out    = cur.sample_enable;                // [R12]
  assign sample_chan_out = cur.sample_enable ? chan_set(cur) : 4'h0;
  assign conv_start_out  = cur.start_p;
  assign conv_done_out   = cur.done_p;
  assign irq_out         = |(cur.irq_stat & cur.irq_mask);
endmodule // asc_core

// >>> dv/asc_trig_src.sv
// asc_trig_src: on-chip trigger sources and external pin for the bench
// assumes go_in is a one-cycle request from the bench, same clock
`timescale 1ns/100ps
module asc_trig_src (
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic [3:0]  sel_in,
  output logic      [11:0] pulse_out,
  output logic             pin_out
);
  int pin_cnt = 0;
  initial pulse_out = 12'h000;
  initial pin_out = 1'b0;
  // index 0..11: one-cycle pulse; index 12: pin held high four cycles
  always @(posedge clk_in) begin
    pulse_out <= (go_in && sel_in < 4'hC) ? 12'h001 << sel_in : 12'h000;
    pin_cnt <= (go_in && sel_in == 4'hC) ? 4 : (pin_cnt > 0 ? pin_cnt - 1 : 0);
    // pin idles low so only the bench request makes an edge
    pin_out <= (go_in && sel_in == 4'hC) || pin_cnt > 1;
  end
endmodule // asc_trig_src

// >>> dv/asc_monitor.sv
// asc_monitor: port-level checks on the sequencer core
// assumes one clock; shadow copies follow the bus writes
`timescale 1ns/100ps
module asc_monitor
  import asc_pkg::*;
#(
  parameter int unsigned CONV_LEN = CONV_CYCLES
) (
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic        ce_in,
  input wire logic [3:0]  addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic        sampling_out,
  input wire logic [3:0]  sample_chan_out,
  input wire logic        conv_start_out,
  input wire logic        conv_done_out,
  input wire logic        irq_out
);
  logic [7:0] ctl;
  logic [2:0] chn;
  logic       msk;
  logic [3:0] want;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctl <= 8'h00;
      chn <= 3'h0;
      msk <= 1'b0;
    end else if (wr_in && ce_in) begin
      if (addr_in == ADDR_CTRL) ctl <= wdata_in[7:0];
      if (addr_in == ADDR_CHAN) chn <= wdata_in[2:0];
      if (addr_in == ADDR_IRQ_MASK) msk <= wdata_in[0];
    end
  end
  // twelve-bit mode forces single-channel sampling
  assign want = (!ctl[3] || chn[2]) ? 4'h1 :
                (chn[1] ? 4'hF : (chn[0] ? 4'h3 : 4'h1));
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  AST_CONV_LEN: assert property (
    conv_start_out |-> ##CONV_LEN conv_done_out)
    else $error("done not at end of conversion");
  AST_HW_CLEAR: assert property (
    conv_start_out |-> $fell(sampling_out))
    else $error("start without sample bit falling");
  AST_ONE_CONV: assert property (
    conv_start_out |=> !conv_start_out [*3])
    else $error("second start inside conversion");
  AST_AUTO_RESAMPLE: assert property (
    conv_done_out && ctl[2] |-> sampling_out)
    else $error("no resample after conversion");
  AST_CHAN_MASK: assert property (
    sample_chan_out == (sampling_out ? want : 4'h0))
    else $error("wrong sampling channel mask");
  AST_CTRL_READ: assert property (
    rd_in && ce_in && addr_in == ADDR_CTRL |=>
      rdata_out[1] == $past(sampling_out) &&
      rdata_out[3] == (ctl[3] && !chn[2]))
    else $error("control readback wrong");
  AST_IRQ_DONE: assert property (
    conv_done_out && msk |=> irq_out)
    else $error("done event raised no irq");
  AST_MAN_START: assert property (
    wr_in && ce_in && addr_in == ADDR_CTRL && ctl[7:4] == 4'h0 &&
      wdata_in[7:4] == 4'h0 && !wdata_in[1] && sampling_out
      |=> conv_start_out)
    else $error("manual clear did not start");
endmodule // asc_monitor

// >>> dv/testbench.sv
// testbench: register port, trigger sources and sampling checks
// assumes asc_core with a short conversion, clock enable high except in the enable test
`timescale 1ns/100ps
module testbench;
  import asc_pkg::*;
  localparam int unsigned CONV_LEN = 4;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [3:0]  addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        ce = 1'b1;
  logic        go = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [11:0] pulse;
  logic        pin;
  logic [15:0] rdata_out;
  logic [3:0]  sample_chan_out;
  logic        sampling_out, conv_start_out, conv_done_out, irq_out;
  logic [15:0] expq[$];
  logic        rd_q = 1'b0;
  logic [15:0] rnd = 16'hC06B;
  logic        hit;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;
  asc_core #(.CONV_LEN(CONV_LEN)) DUT (.clk_in, .rstn_in, .ce_in(ce),
    .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .pwm_pri_in(pulse[2:0]), .tgen_in(pulse[6:3]), .ctu_in(pulse[11]),
    .pwm_sec_sev_in(pulse[10]), .tmr5_in(pulse[9]),
    .pwm_pri_sev_in(pulse[8]), .tmr3_in(pulse[7]), .ext_pin0_in(pin),
    .sampling_out, .sample_chan_out, .conv_start_out, .conv_done_out,
    .irq_out);
  asc_trig_src u_src (.clk_in, .go_in(go), .sel_in(sel),
    .pulse_out(pulse), .pin_out(pin));
  initial forever #25 clk_in = ~clk_in;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // expected read data is queued by the driver, compared by the watcher
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    expq.push_back(e);
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask
  task automatic trig(input int s);
    @(posedge clk_in);
    go <= 1'b1;
    sel <= s[3:0];
    @(posedge clk_in);
    go <= 1'b0;
  endtask
  task automatic wait_ev(input bit dn, output logic h);
    h = 1'b0;
    repeat (12) begin
      @(posedge clk_in);
      if ((dn ? conv_done_out : conv_start_out) === 1'b1) begin
        h = 1'b1;
        break;
      end
    end
  endtask
  task automatic final_report;
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_in) begin
    rd_q <= rd_in;
    if (rd_q) chk(rdata_out, expq.pop_front());
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  // group one: pulse index equals code; group zero maps code to source
  function automatic int src_of(input bit g, input int c);
    return g ? c : (c == 1 ? 12 : c + 5);
  endfunction
  logic [3:0]  ch_t[3] = '{4'h2, 4'h1, 4'h6};
  logic [3:0]  m_t[3] = '{4'hF, 4'h3, 4'h1};
  logic [15:0] rb_t[3] = '{16'h000A, 16'h000A, 16'h0002};
  initial begin
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_IRQ_STAT, 16'h0000);
    rd(ADDR_IRQ_MASK, 16'h0000);
    rd(ADDR_CHAN, 16'h0000);
    rnd = lfsr(rnd);
    wr(4'h4 + rnd[2:0], rnd);
    rd(4'h4 + rnd[2:0], 16'h0000);
    $display("test reset done");
    wr(ADDR_IRQ_MASK, 16'h0001);
    rd(ADDR_IRQ_MASK, 16'h0001);
    wr(ADDR_CTRL, 16'h0002);
    rd(ADDR_CTRL, 16'h0002);
    chk(sample_chan_out, 4'h1);
    wr(ADDR_CTRL, 16'h0000);
    wait_ev(1, hit);
    rd(ADDR_CTRL, 16'h0001);
    chk(irq_out, 1'b1);
    rd(ADDR_IRQ_STAT, 16'h0003);
    wr(ADDR_IRQ_STAT, 16'h0003);
    rd(ADDR_IRQ_STAT, 16'h0000);
    chk(irq_out, 1'b0);
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_CTRL, 16'h0001);
    rd(ADDR_CTRL, 16'h0000);
    wr(ADDR_CTRL, 16'h0002);
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_CTRL, 16'h0000);
    wait_ev(1, hit);
    rd(ADDR_CTRL, 16'h0001);
    // write one keeps done, so only the start can clear it
    wr(ADDR_CTRL, 16'h0003);
    wr(ADDR_CTRL, 16'h0001);
    rd(ADDR_CTRL, 16'h0000);
    wait_ev(1, hit);
    chk(hit, 1'b1);
    $display("test manual done");
    for (int g = 0; g < 2; g++) begin
      for (int c = g ? 0 : 1; c < 8; c++) begin
        wr(ADDR_CTRL, {8'h00, c[2:0], g[0], 4'h2});
        if (g == 1 || c != 7) begin
          trig((src_of(g, c) + 1) % 13);
          repeat (4) @(posedge clk_in);
          chk(sampling_out, 1'b1);
          trig(src_of(g, c));
        end
        wait_ev(0, hit);
        chk(hit, !(g == 1 && c == 7));
        if (hit !== 1'b1) begin
          wr(ADDR_CTRL, 16'h0002);
          wr(ADDR_CTRL, 16'h0000);
        end
        wait_ev(1, hit);
        rd(ADDR_CTRL, (hit === 1'b1 && !(g == 1 && c == 7)) ?
          {8'h00, c[2:0], g[0], 4'h1} : 16'h0001);
      end
    end
    $display("test triggers done");
    wr(ADDR_CTRL, 16'h00E6);
    wait_ev(1, hit);
    chk(sampling_out, 1'b1);
    wait_ev(1, hit);
    chk(sampling_out, 1'b1);
    wr(ADDR_CTRL, 16'h00E1);
    wait_ev(1, hit);
    repeat (6) @(posedge clk_in);
    chk(sampling_out, 1'b0);
    rd(ADDR_CTRL, 16'h00E1);
    $display("test auto done");
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CHAN, {12'h000, ch_t[i]});
      rd(ADDR_CHAN, {12'h000, ch_t[i]});
      wr(ADDR_CTRL, 16'h000A);
      rd(ADDR_CTRL, rb_t[i]);
      chk(sample_chan_out, m_t[i]);
      wr(ADDR_CTRL, 16'h0000);
      wait_ev(1, hit);
    end
    $display("test simultaneous done");
    // enable low freezes everything, bus writes included
    wr(ADDR_CTRL, 16'h0002);
    @(posedge clk_in);
    ce <= 1'b0;
    wr(ADDR_CTRL, 16'h0000);
    repeat (3) @(posedge clk_in);
    chk(sampling_out, 1'b1);
    ce <= 1'b1;
    rd(ADDR_CTRL, 16'h0002);
    wr(ADDR_CTRL, 16'h0000);
    wait_ev(1, hit);
    chk(hit, 1'b1);
    $display("test enable done");
    final_report();
  end
endmodule // testbench
bind asc_core asc_monitor #(.CONV_LEN(CONV_LEN)) u_mon (.clk_in, .rstn_in,
  .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .sampling_out,
  .sample_chan_out, .conv_start_out, .conv_done_out, .irq_out);
